// ### rtl/fprp_top.sv
// floating-point result postprocessing: underflow, rounding, overflow, condition codes, tests
`timescale 1ns/1ns
`include "fprp_map.svh"
module fprp_top
  import fprp_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic [31:0]             dat_o,
  output logic                    ack_o,
  input  wire logic               op_valid_i,
  input  wire fprp_kind_t         op_kind_i,
  input  wire logic               op_sign_i,
  input  wire fprp_cls_t          op_cls_i,
  input  wire logic signed [17:0] op_exp_i,
  input  wire logic [66:0]        op_mant_i,
  output logic                    done_o,
  output logic                    res_sign_o,
  output logic [14:0]             res_exp_o,
  output logic [63:0]             res_mant_o,
  output fprp_cc_t                cc_o,
  output logic                    underflow_flag_o,
  output logic                    overflow_flag_o,
  output logic                    inex_o,
  input  wire logic               test_valid_i,
  input  wire fprp_pred_t         test_pred_i,
  output logic                    test_done_o,
  output logic                    test_true_o,
  output logic                    test_ubr_o,
  output logic                    test_trap_o
);

  //////////////////////////////////////////////////////////////////////////////
  // control register fields
  logic [15:0] ctrl;
  fprp_rnd_t   rnd;
  fprp_prec_t  prec;
  assign rnd  = ctrl[`FPRP_CTRL_RND];
  assign prec = ctrl[`FPRP_CTRL_PREC];

  // the undefined precision code falls back to extended rather than faulting
  wire [1:0] prec_eff = (prec == `FPRP_PREC_UNDEF) ? `FPRP_PREC_EXT : prec;

  logic [6:0]         lsb;
  logic signed [17:0] emin;
  logic signed [17:0] emax;
  always_comb begin
    case (prec_eff)
      `FPRP_PREC_SGL: begin
        lsb  = `FPRP_LSB_SGL;
        emin = $signed(`FPRP_EMIN_SGL);
        emax = $signed(`FPRP_EMAX_SGL);
      end
      `FPRP_PREC_DBL: begin
        lsb  = `FPRP_LSB_DBL;
        emin = $signed(`FPRP_EMIN_DBL);
        emax = $signed(`FPRP_EMAX_DBL);
      end
      default: begin
        lsb  = `FPRP_LSB_EXT;
        emin = $signed(`FPRP_EMIN_EXT);
        emax = $signed(`FPRP_EMAX_EXT);
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // underflow detection and denormalization (18-bit exponent, 67-bit mantissa)
  wire               is_fin    = (op_cls_i == `FPRP_CLS_FIN);
  wire               below     = is_fin & (op_exp_i < emin);
  wire signed [17:0] shift_amt = emin - op_exp_i;
  wire [6:0]         shamt     = ~below ? 7'h00 :
                                 (shift_amt > $signed(`FPRP_MANT_SPAN)) ? `FPRP_SHIFT_MAX : shift_amt[6:0];
  wire [66:0]        den_mant  = op_mant_i >> shamt;
  wire [66:0]        rnd_src   = below ? den_mant : op_mant_i;

  logic [63:0] rnd_mant;
  logic        rnd_carry;
  logic        rnd_inexact;
  logic        kept_zero;
  fprp_round #(.MW(67)) u_round (
    .mant_i      (rnd_src),
    .lsb_i       (lsb),
    .sign_i      (op_sign_i),
    .rnd_i       (rnd),
    .mant_o      (rnd_mant),
    .carry_o     (rnd_carry),
    .inexact_o   (rnd_inexact),
    .kept_zero_o (kept_zero)
  );

  wire gross     = below & kept_zero;
  // directed rounding away from zero keeps the smallest denormal instead of zero
  wire gross_min = (rnd == `FPRP_RND_PLUS & ~op_sign_i) | (rnd == `FPRP_RND_MINUS & op_sign_i);

  //////////////////////////////////////////////////////////////////////////////
  // overflow after rounding
  wire signed [17:0] exp_r  = op_exp_i + {17'h00000, rnd_carry};
  wire               ovf    = is_fin & ~below & (exp_r > emax);
  wire               to_inf = (rnd == `FPRP_RND_NEAR) |
                              (rnd == `FPRP_RND_MINUS & op_sign_i) |
                              (rnd == `FPRP_RND_PLUS & ~op_sign_i);
  wire [66:0]        one67  = {66'h0, 1'b1};
  wire [66:0]        top_m  = ~((one67 << lsb) - one67);
  wire [63:0]        max_mant = top_m[66:3];
  wire [66:0]        min67  = one67 << lsb;
  wire [63:0]        min_mant = min67[66:3];
  wire signed [17:0] exp_b  = exp_r + $signed(`FPRP_EXP_BIAS);
  wire signed [17:0] emax_b = emax + $signed(`FPRP_EXP_BIAS);
  wire signed [17:0] emin_b = emin + $signed(`FPRP_EXP_BIAS);
  // extended denormals carry a zero exponent field; narrower ones sit at their own minimum
  wire [14:0]        den_exp = (prec_eff == `FPRP_PREC_EXT) ? 15'h0000 : emin_b[14:0];

  //////////////////////////////////////////////////////////////////////////////
  // final value selection
  logic [14:0] next_exp;
  logic [63:0] next_mant;
  fprp_cls_t   next_cls;
  logic        next_unf;
  logic        next_ovf;
  logic        next_inx;
  always_comb begin
    next_exp  = 15'h0000;
    next_mant = 64'h0;
    next_cls  = op_cls_i;
    next_unf  = 1'b0;
    next_ovf  = 1'b0;
    next_inx  = 1'b0;
    case (op_cls_i)
      `FPRP_CLS_INF: next_exp = `FPRP_EXP_INF;
      `FPRP_CLS_NAN: begin
        next_exp  = `FPRP_EXP_INF;
        next_mant = op_mant_i[66:3];
      end
      `FPRP_CLS_FIN: begin
        if (below) begin
          next_unf = 1'b1;
          next_inx = rnd_inexact;
          if (gross) begin
            next_inx  = 1'b1;
            next_cls  = gross_min ? `FPRP_CLS_FIN : `FPRP_CLS_ZERO;
            next_mant = gross_min ? min_mant : 64'h0;
            next_exp  = gross_min ? den_exp : 15'h0000;
          end else begin
            next_mant = rnd_mant;
            next_exp  = den_exp;
          end
        end else if (ovf) begin
          next_ovf  = 1'b1;
          next_inx  = 1'b1;
          next_cls  = to_inf ? `FPRP_CLS_INF : `FPRP_CLS_FIN;
          next_exp  = to_inf ? `FPRP_EXP_INF : emax_b[14:0];
          next_mant = to_inf ? 64'h0 : max_mant;
        end else begin
          next_inx  = rnd_inexact;
          next_mant = rnd_mant;
          next_exp  = exp_b[14:0];
          next_cls  = (rnd_mant == 64'h0) ? `FPRP_CLS_ZERO : `FPRP_CLS_FIN;
        end
      end
      default: next_cls = `FPRP_CLS_ZERO;
    endcase
  end

  // the code bits come from the delivered type and sign only; a compare against a NaN
  // arrives as a NaN-class result and so lands on the unordered bit
  wire [3:0] next_cc = {op_sign_i,
                        next_cls == `FPRP_CLS_ZERO,
                        next_cls == `FPRP_CLS_INF,
                        next_cls == `FPRP_CLS_NAN};
  wire cc_upd = op_valid_i & (op_kind_i != `FPRP_KIND_NONE);

  //////////////////////////////////////////////////////////////////////////////
  // conditional test evaluation against the current codes
  logic cond_true;
  logic cond_sig;
  fprp_cond u_cond (
    .cc_i     (cc_o),
    .pred_i   (test_pred_i),
    .true_o   (cond_true),
    .signal_o (cond_sig)
  );
  wire ubr_set = test_valid_i & cond_sig;

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack registered
  wire       bus_req  = cyc_i & stb_i;
  wire       bus_wr   = bus_req & we_i & ack_o;
  wire       hit_ctrl = (adr_i == `FPRP_ADR_CTRL);
  wire       hit_stat = (adr_i == `FPRP_ADR_STAT);
  wire [7:0] exc_clr  = (bus_wr & hit_stat & sel_i[1]) ? dat_i[15:8] : 8'h00;
  wire       cc_load  = bus_wr & hit_stat & sel_i[3];
  logic      ubr;
  logic      ubr_en;
  assign ubr_en = ctrl[`FPRP_CTRL_UBR_EN];

  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0;
    stat_word[`FPRP_STAT_CC]  = cc_o;
    stat_word[`FPRP_STAT_UBR] = ubr;
    stat_word[`FPRP_STAT_OVF] = overflow_flag_o;
    stat_word[`FPRP_STAT_UNF] = underflow_flag_o;
    stat_word[`FPRP_STAT_INX] = inex_o;
  end
  wire [31:0] rd_mux = hit_ctrl ? {16'h0, ctrl} :
                       hit_stat ? stat_word :
                       (adr_i == `FPRP_ADR_RES_EXP) ? {res_sign_o, 16'h0, res_exp_o} :
                       (adr_i == `FPRP_ADR_RES_HI)  ? res_mant_o[63:32] :
                       (adr_i == `FPRP_ADR_RES_LO)  ? res_mant_o[31:0] : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= bus_req & ~ack_o;
      dat_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `FPRP_CTRL_RST;
    end else if (bus_wr & hit_ctrl) begin
      if (sel_i[0]) ctrl[7:0]  <= dat_i[7:0];
      if (sel_i[1]) ctrl[15:8] <= dat_i[15:8];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // completion register: value, codes and flags land on the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o     <= 1'b0;
      res_sign_o <= 1'b0;
      res_exp_o  <= 15'h0000;
      res_mant_o <= 64'h0;
    end else begin
      done_o <= op_valid_i;
      if (op_valid_i) begin
        res_sign_o <= op_sign_i;
        res_exp_o  <= next_exp;
        res_mant_o <= next_mant;
      end
    end
  end

  // hardware updates win over a software clear or load in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc_o   <= 4'h0;
      underflow_flag_o <= 1'b0;
      overflow_flag_o <= 1'b0;
      inex_o <= 1'b0;
      ubr    <= 1'b0;
    end else begin
      if (cc_upd) cc_o <= next_cc;
      else if (cc_load) cc_o <= dat_i[`FPRP_STAT_CC];
      if (cc_upd) begin
        underflow_flag_o <= next_unf;
        overflow_flag_o <= next_ovf;
        inex_o <= next_inx;
      end else begin
        underflow_flag_o <= underflow_flag_o & ~exc_clr[`FPRP_STAT_UNF - 8];
        overflow_flag_o <= overflow_flag_o & ~exc_clr[`FPRP_STAT_OVF - 8];
        inex_o <= inex_o & ~exc_clr[`FPRP_STAT_INX - 8];
      end
      ubr <= (ubr & ~exc_clr[`FPRP_STAT_UBR - 8]) | ubr_set;
    end
  end

  // a test issued in the same cycle as an update sees the codes from before it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_done_o <= 1'b0;
      test_true_o <= 1'b0;
      test_ubr_o  <= 1'b0;
      test_trap_o <= 1'b0;
    end else begin
      test_done_o <= test_valid_i;
      test_true_o <= test_valid_i & cond_true;
      test_ubr_o  <= ubr_set;
      test_trap_o <= ubr_set & ubr_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_DONE_TOGETHER: assert property (op_valid_i |=> done_o && res_sign_o == $past(op_sign_i))
    else $error("completion missing one cycle after op");
  AST_NAN_RESULT: assert property (op_valid_i && op_cls_i == `FPRP_CLS_NAN && cc_upd
    |=> done_o && cc_o[`FPRP_CC_NAN] && !cc_o[`FPRP_CC_Z])
    else $error("nan result did not set unordered bit");
  AST_CC_HOLD: assert property (op_valid_i && op_kind_i == `FPRP_KIND_NONE && !cc_load
    |=> $stable(cc_o))
    else $error("codes changed on a non-updating op");
  AST_CC_TYPES: assert property (cc_upd |=> $onehot0(cc_o[2:0]))
    else $error("zero, infinity and unordered not exclusive");
  AST_SIGN_N: assert property (cc_upd |=> cc_o[`FPRP_CC_N] == res_sign_o)
    else $error("negative bit does not follow sign");
  AST_OVF_VALUE: assert property (cc_upd && ovf |=> overflow_flag_o && inex_o &&
    (cc_o[`FPRP_CC_I] || (res_mant_o[63] && !cc_o[`FPRP_CC_NAN])))
    else $error("overflow result neither infinity nor largest");
  AST_UNF_NOOVF: assert property (done_o && underflow_flag_o |-> !overflow_flag_o)
    else $error("underflow and overflow together");
  AST_GROSS_ZERO: assert property (op_valid_i && gross && !gross_min && cc_upd
    |=> underflow_flag_o && cc_o[`FPRP_CC_Z] && res_mant_o == 64'h0)
    else $error("gross underflow did not return zero");
  AST_NGT_UNORD: assert property (test_valid_i && test_pred_i == `FPRP_PRED_NGT && cc_o[`FPRP_CC_NAN]
    |=> test_true_o && test_ubr_o && ubr)
    else $error("not-greater wrong on unordered");
  AST_GT_LE_UNORD: assert property (test_valid_i && cc_o[`FPRP_CC_NAN] &&
    (test_pred_i == `FPRP_PRED_GT || test_pred_i == `FPRP_PRED_LE)
    |=> !test_true_o && test_ubr_o)
    else $error("greater or less-equal wrong on unordered");
  AST_QUIET_TESTS: assert property (test_valid_i && !test_pred_i[4] |=> !test_ubr_o && !test_trap_o)
    else $error("non-signalling test raised unordered-branch");
  AST_TRAP_EN: assert property (test_valid_i && test_pred_i == `FPRP_PRED_ST && cc_o[`FPRP_CC_NAN]
    |=> test_true_o && (test_trap_o == $past(ubr_en)))
    else $error("trap does not follow enable");
  AST_ORDERED_GT: assert property (test_valid_i && test_pred_i == `FPRP_PRED_OGT
    |=> test_true_o == !($past(cc_o[`FPRP_CC_N]) || $past(cc_o[`FPRP_CC_Z]) || $past(cc_o[`FPRP_CC_NAN])))
    else $error("ordered greater wrong");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  COV_GROSS_MIN: cover property (op_valid_i && gross && gross_min);
  COV_OVF_MAX: cover property (op_valid_i && ovf && !to_inf);
  COV_TRAP: cover property (test_trap_o);
  COV_DENORM: cover property (op_valid_i && below && !gross);

endmodule : fprp_top

// ### rtl/fprp_map.svh
// register map, field positions, encodings and range constants of the result postprocessing stage
`ifndef FPRP_MAP_SVH
`define FPRP_MAP_SVH
`define FPRP_ADR_CTRL     8'h00
`define FPRP_ADR_STAT     8'h04
`define FPRP_ADR_RES_EXP  8'h08
`define FPRP_ADR_RES_HI   8'h0c
`define FPRP_ADR_RES_LO   8'h10
`define FPRP_CTRL_RND     5:4
`define FPRP_CTRL_PREC    7:6
`define FPRP_CTRL_UBR_EN  15
`define FPRP_CTRL_RST     16'h0000
`define FPRP_STAT_CC      27:24
`define FPRP_STAT_UBR     15
`define FPRP_STAT_OVF     12
`define FPRP_STAT_UNF     11
`define FPRP_STAT_INX     9
`define FPRP_CC_N         3
`define FPRP_CC_Z         2
`define FPRP_CC_I         1
`define FPRP_CC_NAN       0
`define FPRP_RND_NEAR     2'h0
`define FPRP_RND_ZERO     2'h1
`define FPRP_RND_MINUS    2'h2
`define FPRP_RND_PLUS     2'h3
`define FPRP_PREC_EXT     2'h0
`define FPRP_PREC_SGL     2'h1
`define FPRP_PREC_DBL     2'h2
`define FPRP_PREC_UNDEF   2'h3
`define FPRP_CLS_FIN      2'h0
`define FPRP_CLS_ZERO     2'h1
`define FPRP_CLS_INF      2'h2
`define FPRP_CLS_NAN      2'h3
`define FPRP_KIND_ARITH   2'h0
`define FPRP_KIND_MOVE    2'h1
`define FPRP_KIND_CMP     2'h2
`define FPRP_KIND_NONE    2'h3
`define FPRP_LSB_EXT      7'h03
`define FPRP_LSB_SGL      7'h2b
`define FPRP_LSB_DBL      7'h0e
`define FPRP_MANT_SPAN    18'h00043
`define FPRP_SHIFT_MAX    7'h43
`define FPRP_EMIN_EXT     18'h3c002
`define FPRP_EMAX_EXT     18'h03fff
`define FPRP_EMIN_SGL     18'h3ff82
`define FPRP_EMAX_SGL     18'h0007f
`define FPRP_EMIN_DBL     18'h3fc02
`define FPRP_EMAX_DBL     18'h003ff
`define FPRP_EXP_BIAS     18'h03fff
`define FPRP_EXP_INF      15'h7fff
`define FPRP_PRED_EQ      6'h01
`define FPRP_PRED_OGT     6'h02
`define FPRP_PRED_T       6'h0f
`define FPRP_PRED_GT      6'h12
`define FPRP_PRED_LE      6'h15
`define FPRP_PRED_NGT     6'h1d
`define FPRP_PRED_ST      6'h1f
`endif

// ### rtl/fprp_pkg.sv
// shared types of the result postprocessing stage
package fprp_pkg;
  typedef logic [1:0] fprp_rnd_t;
  typedef logic [1:0] fprp_prec_t;
  typedef logic [1:0] fprp_cls_t;
  typedef logic [1:0] fprp_kind_t;
  typedef logic [3:0] fprp_cc_t;
  typedef logic [5:0] fprp_pred_t;
endpackage : fprp_pkg

// ### rtl/fprp_round.sv
// mantissa rounder: masks to the precision boundary and applies the mode increment
`timescale 1ns/1ns
`include "fprp_map.svh"
module fprp_round
  import fprp_pkg::*;
#(
  parameter int MW = 67
) (
  input  wire logic [MW-1:0] mant_i,
  input  wire logic [6:0]    lsb_i,
  input  wire logic          sign_i,
  input  wire fprp_rnd_t     rnd_i,
  output logic [MW-4:0]      mant_o,
  output logic               carry_o,
  output logic               inexact_o,
  output logic               kept_zero_o
);
  wire [MW-1:0] one       = {{(MW-1){1'b0}}, 1'b1};
  wire [MW-1:0] low_mask  = (one << lsb_i) - one;
  wire [MW-1:0] kept      = mant_i & ~low_mask;
  wire          lost      = |(mant_i & low_mask);
  wire          half      = mant_i[lsb_i - 7'h01];
  wire          rest      = |(mant_i & (low_mask >> 1));
  wire          lsb_bit   = mant_i[lsb_i];
  logic         inc;
  always_comb begin
    case (rnd_i)
      `FPRP_RND_NEAR:  inc = half & (rest | lsb_bit);  // ties go to even
      `FPRP_RND_ZERO:  inc = 1'b0;
      `FPRP_RND_MINUS: inc = sign_i & lost;
      `FPRP_RND_PLUS:  inc = ~sign_i & lost;
      default:         inc = 1'b0;
    endcase
  end
  wire [MW:0] sum = {1'b0, kept} + (inc ? {1'b0, one << lsb_i} : {(MW+1){1'b0}});
  assign carry_o     = sum[MW];
  assign mant_o      = sum[MW] ? sum[MW:4] : sum[MW-1:3];
  assign inexact_o   = lost;
  assign kept_zero_o = ~|kept;
endmodule : fprp_round

// ### rtl/fprp_cond.sv
// conditional test evaluator over the N, Z and unordered condition code bits
`timescale 1ns/1ns
`include "fprp_map.svh"
module fprp_cond
  import fprp_pkg::*;
(
  input  wire fprp_cc_t   cc_i,
  input  wire fprp_pred_t pred_i,
  output logic            true_o,
  output logic            signal_o
);
  wire n   = cc_i[`FPRP_CC_N];
  wire z   = cc_i[`FPRP_CC_Z];
  wire unordered_bit = cc_i[`FPRP_CC_NAN];
  wire [15:0] tests;
  assign tests[0]  = 1'b0;
  assign tests[1]  = z;
  assign tests[2]  = ~unordered_bit & ~z & ~n;
  assign tests[3]  = z | (~unordered_bit & ~n);
  assign tests[4]  = n & ~unordered_bit & ~z;
  assign tests[5]  = z | (n & ~unordered_bit);
  assign tests[6]  = ~unordered_bit & ~z;
  assign tests[7]  = ~unordered_bit;
  assign tests[8]  = unordered_bit;
  assign tests[9]  = unordered_bit | z;
  assign tests[10] = unordered_bit | ~(n | z);
  assign tests[11] = unordered_bit | z | ~n;
  assign tests[12] = unordered_bit | (n & ~z);
  assign tests[13] = unordered_bit | z | n;
  assign tests[14] = ~z;
  assign tests[15] = 1'b1;
  // codes with the top bit set are not tests: false and silent
  assign true_o   = ~pred_i[5] & tests[pred_i[3:0]];
  assign signal_o = ~pred_i[5] & pred_i[4] & unordered_bit;
endmodule : fprp_cond

// ### test/fprp_far_model.sv
// partner model: arithmetic unit and conditional sequencer feeding the stage
`timescale 1ns/1ns
module fprp_far_model
  import fprp_pkg::*;
(
  input  wire logic               clk_i,
  output logic                    v_o,
  output fprp_kind_t              k_o,
  output logic                    s_o,
  output fprp_cls_t               c_o,
  output logic signed [17:0]      e_o,
  output logic [66:0]             m_o,
  output logic                    tv_o,
  output fprp_pred_t              p_o
);
  initial begin
    {v_o, k_o, s_o, c_o, e_o, m_o, tv_o, p_o} = '0;
  end
  // sign, exponent, mantissa and predicate are inverted after the take edge so stale values never look valid
  task op(input fprp_kind_t k, input logic s, input fprp_cls_t c, input logic signed [17:0] e,
          input logic [66:0] m);
    @(posedge clk_i);
    v_o <= 1'b1; k_o <= k; s_o <= s; c_o <= c; e_o <= e; m_o <= m;
    @(posedge clk_i);
    v_o <= 1'b0; s_o <= ~s; e_o <= ~e; m_o <= ~m;
    @(negedge clk_i);
  endtask : op
  task tst(input fprp_pred_t p);
    @(posedge clk_i);
    tv_o <= 1'b1; p_o <= p;
    @(posedge clk_i);
    tv_o <= 1'b0; p_o <= ~p;
    @(negedge clk_i);
  endtask : tst
endmodule : fprp_far_model

// ### test/test_fprp_top.sv
// self-checking bench of the result postprocessing stage
`timescale 1ns/1ns
module test_fprp_top;
  import fprp_pkg::*;
  localparam logic [66:0] ONE = {1'b1, 66'h0};
  logic clk_i, rst_i, cyc, stb, we, ack, v, s, tv, done, rs, unf, ovf, inx, td, tt, tu, tr;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [3:0] lanes = 4'hf;
  logic [31:0] dat, rd, q;
  fprp_kind_t k;
  fprp_cls_t c;
  logic signed [17:0] e;
  logic [66:0] m;
  logic [14:0] rx;
  logic [63:0] rm;
  fprp_cc_t cc;
  fprp_pred_t p;
  int num_errors = 0;
  int checks = 0;
  fprp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(rd), .ack_o(ack), .op_valid_i(v), .op_kind_i(k), .op_sign_i(s),
    .op_cls_i(c), .op_exp_i(e), .op_mant_i(m), .done_o(done), .res_sign_o(rs), .res_exp_o(rx),
    .res_mant_o(rm), .cc_o(cc), .underflow_flag_o(unf), .overflow_flag_o(ovf), .inex_o(inx), .test_valid_i(tv),
    .test_pred_i(p), .test_done_o(td), .test_true_o(tt), .test_ubr_o(tu), .test_trap_o(tr));
  fprp_far_model u_far (.clk_i(clk_i), .v_o(v), .k_o(k), .s_o(s), .c_o(c), .e_o(e), .m_o(m),
    .tv_o(tv), .p_o(p));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task chk(input string n, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= lanes; dat <= d;
    // ack and read data are taken at the same rising edge, before that edge updates them
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) num_errors++;
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  task t_class;
    for (int i = 0; i < 8; i++) begin
      u_far.op(2'h0, i[2], i[1:0], 18'sh0, ONE);
      chk("done", done, 1);
      chk("cc", cc, {i[2], i[1:0] == 2'h1, i[1:0] == 2'h2, i[1:0] == 2'h3});
    end
    u_far.op(2'h1, 1'b1, 2'h1, 18'sh0, ONE);
    chk("cc move", cc, 4'hc);
    u_far.op(2'h3, 1'b0, 2'h3, 18'sh0, ONE);
    chk("cc kept", cc, 4'hc);
    u_far.op(2'h2, 1'b0, 2'h3, 18'sh0, ONE);
    chk("cc cmp", cc, 4'h1);
    $display("class test done");
  endtask : t_class
  task t_round;
    wb(1'b1, 8'h00, 32'h10);
    u_far.op(2'h0, 1'b0, 2'h0, 18'sh0, ONE | 67'h4);
    chk("rz mant", rm, 64'h8000000000000000);
    chk("rz inex", inx, 1);
    wb(1'b1, 8'h00, 32'h30);
    u_far.op(2'h0, 1'b0, 2'h0, 18'sh0, ONE | 67'h4);
    chk("rp mant", rm, 64'h8000000000000001);
    u_far.op(2'h0, 1'b0, 2'h0, -18'sd20000, ONE);
    chk("gross rp", {unf, rx, rm}, {1'b1, 15'h0, 64'h1});
    wb(1'b1, 8'h00, 32'h0);
    u_far.op(2'h0, 1'b1, 2'h0, -18'sd20000, ONE);
    chk("gross rn", {unf, cc}, 5'h1c);
    u_far.op(2'h0, 1'b1, 2'h0, 18'sd16384, ONE);
    chk("ovf rn", {ovf, rx, rm, cc}, {1'b1, 15'h7fff, 64'h0, 4'ha});
    wb(1'b1, 8'h00, 32'h10);
    u_far.op(2'h0, 1'b0, 2'h0, 18'sd16384, ONE);
    chk("ovf rz", {ovf, rx, rm, cc}, {1'b1, 15'h7ffe, 64'hffffffffffffffff, 4'h0});
    $display("round test done");
  endtask : t_round
  task t_cond;
    wb(1'b1, 8'h00, 32'h0);
    u_far.op(2'h0, 1'b0, 2'h3, 18'sh0, ONE);
    u_far.tst(6'h1d);
    chk("ngt", {td, tt, tu}, 3'h7);
    u_far.tst(6'h12);
    chk("gt", {tt, tu}, 2'h1);
    u_far.tst(6'h15);
    chk("le", {tt, tu, tr}, 3'h2);
    u_far.tst(6'h01);
    chk("eq", {tt, tu}, 2'h0);
    u_far.tst(6'h02);
    chk("ogt", {tt, tu}, 2'h0);
    wb(1'b0, 8'h04, 32'h0);
    chk("stat ubr", q[15], 1);
    wb(1'b1, 8'h00, 32'h8000);
    u_far.tst(6'h1f);
    chk("st trap", {tt, tu, tr}, 3'h7);
    u_far.op(2'h0, 1'b0, 2'h0, 18'sh0, ONE);
    u_far.tst(6'h12);
    chk("gt ord", {tt, tu, tr}, 3'h4);
    u_far.tst(6'h0f);
    chk("true", tt, 1);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 0);
    $display("cond test done");
  endtask : t_cond
  task t_bus;
    lanes = 4'h1;
    wb(1'b1, 8'h00, 32'h0000ff20);
    lanes = 4'hf;
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl lane", q, 32'h00008020);
    u_far.op(2'h0, 1'b0, 2'h0, 18'sd16384, ONE);
    chk("ovf rm", {ovf, inx, rx, cc}, {1'b1, 1'b1, 15'h7ffe, 4'h0});
    lanes = 4'h2;
    wb(1'b1, 8'h04, 32'h00009000);
    lanes = 4'h8;
    wb(1'b1, 8'h04, 32'h0100ff00);
    lanes = 4'hf;
    wb(1'b0, 8'h04, 32'h0);
    chk("stat clr load", q, 32'h01000200);
    u_far.tst(6'h12);
    chk("gt loaded", {tt, tu, tr}, 3'h3);
    wb(1'b1, 8'h00, 32'h40);
    u_far.op(2'h0, 1'b0, 2'h0, 18'sh0, ONE | (67'h3 << 41));
    chk("sgl rn", {inx, rm}, {1'b1, 64'h8000010000000000});
    u_far.op(2'h0, 1'b0, 2'h0, -18'sd127, ONE);
    chk("sgl denorm", {unf, inx, rx, rm}, {1'b1, 1'b0, 15'h3f81, 64'h4000000000000000});
    wb(1'b1, 8'h00, 32'h80);
    u_far.op(2'h0, 1'b0, 2'h0, 18'sd1024, ONE);
    chk("dbl ovf", {ovf, rx, cc}, {1'b1, 15'h7fff, 4'h2});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk("rst ctrl", q, 0);
    chk("rst state", {done, cc, unf, ovf, inx, td}, 9'h0);
    $display("bus test done");
  endtask : t_bus
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl rst", q, 0);
    t_class;
    t_round;
    t_cond;
    t_bus;
    print_verdict;
  end
  initial begin
    #400000;
    num_errors++;
    print_verdict;
  end
endmodule : test_fprp_top
